/* hdl/eas_defs.svh */
`ifndef EAS_DEFS_SVH
`define EAS_DEFS_SVH
// area codes on physical address bits 28..26
`define EAS_AREA_LSB 26
`define EAS_AREA_MSB 28
`define EAS_AREA2 3'h2
`define EAS_AREA3 3'h3
`define EAS_AREA4 3'h4
`define EAS_AREA5 3'h5
`define EAS_AREA6 3'h6
// bit 25 splits a 64 Mbyte area into two 32 Mbyte halves
`define EAS_HALF_BIT 25
// wait limits
`define EAS_WAIT3_MAX 4'h3
`define EAS_WAIT_MAX 4'ha
// least burst pitch in clocks
`define EAS_PITCH_MIN 4'h2
// width field codes
`define EAS_WIDTH_LONG 2'h3
`endif

/* hdl/eas_pkg.sv */
package eas_pkg;
  typedef enum logic [2:0] {
    EAS_MEM_NORMAL,
    EAS_MEM_BURST_ROM,
    EAS_MEM_DRAM,
    EAS_MEM_PSRAM,
    EAS_MEM_SDRAM,
    EAS_MEM_CARD
  } eas_mem_e;
  typedef enum logic [2:0] {
    EAS_IDLE,
    EAS_SETUP,
    EAS_WAIT,
    EAS_STROBE,
    EAS_HOLD
  } eas_state_e;
endpackage

/* hdl/eas_area_decode.sv */
`timescale 1ns/1ns
`include "eas_defs.svh"
// ---------------------------------------------------------------
// area decode, bits 31..29 ignored so each area repeats
// ---------------------------------------------------------------
module eas_area_decode (
  input wire logic [31:0] addr_i,
  output logic [6:2] hit_o,
  output logic upper_half_o
);
  logic [2:0] code;
  assign code = addr_i[`EAS_AREA_MSB:`EAS_AREA_LSB];
  assign hit_o[2] = (code == `EAS_AREA2);
  assign hit_o[3] = (code == `EAS_AREA3);
  assign hit_o[4] = (code == `EAS_AREA4);
  assign hit_o[5] = (code == `EAS_AREA5);
  assign hit_o[6] = (code == `EAS_AREA6);
  assign upper_half_o = addr_i[`EAS_HALF_BIT];
endmodule

/* hdl/eas_wait_calc.sv */
`timescale 1ns/1ns
`include "eas_defs.svh"
// ---------------------------------------------------------------
// software wait count for the addressed area, clamped to its limit
// ---------------------------------------------------------------
module eas_wait_calc (
  input wire logic [6:2] hit_i,
  input wire logic [1:0] area3_wait_field_i,
  input wire logic [3:0] area4_wait_field_i,
  input wire logic [3:0] area5_wait_field_i,
  input wire logic [3:0] area6_wait_field_i,
  output logic [3:0] waits_o
);
  logic [3:0] raw;
  always_comb begin
    raw = 4'h0;
    if (hit_i[3]) begin
      raw = {2'b00, area3_wait_field_i};
    end else if (hit_i[4]) begin
      raw = area4_wait_field_i;
    end else if (hit_i[5]) begin
      raw = area5_wait_field_i;
    end else if (hit_i[6]) begin
      raw = area6_wait_field_i;
    end
    // out-of-range codes saturate rather than overflow the pitch
    waits_o = (raw > `EAS_WAIT_MAX) ? `EAS_WAIT_MAX : raw;
  end
endmodule

/* hdl/eas_select.sv */
`timescale 1ns/1ns
`include "eas_defs.svh"
module eas_select
  import eas_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic srst_i,
  input wire logic req_i,
  input wire logic [31:0] addr_i,
  input wire logic write_i,
  input wire logic [3:0] byte_en_i,
  input wire logic burst_i,
  input wire logic ext_wait_n_i,
  input wire eas_mem_e area2_type_i,
  input wire eas_mem_e area3_type_i,
  input wire eas_mem_e area5_type_i,
  input wire eas_mem_e area6_type_i,
  input wire logic [1:0] area3_width_field_i,
  input wire logic [1:0] area5_width_field_i,
  input wire logic [1:0] area6_width_field_i,
  input wire logic memory_width_bit_i,
  input wire logic [1:0] area3_wait_field_i,
  input wire logic [3:0] area4_wait_field_i,
  input wire logic [3:0] area5_wait_field_i,
  input wire logic [3:0] area6_wait_field_i,
  input wire logic [1:0] area5_strobe_setup_i,
  input wire logic [1:0] area5_strobe_hold_i,
  input wire logic [1:0] area6_strobe_setup_i,
  input wire logic [1:0] area6_strobe_hold_i,
  output logic busy_o,
  output logic done_o,
  output logic unmapped_o,
  output logic [1:0] bus_width_o,
  output logic [3:0] burst_pitch_o,
  output logic addr_mux_o,
  output logic area3_select_n_o,
  output logic area4_select_n_o,
  output logic area5_select_n_o,
  output logic area6_select_n_o,
  output logic read_strobe_n_o,
  output logic [3:0] byte_write_strobe_n_o,
  output logic row_strobe_n_o,
  output logic col_strobe_n_o,
  output logic col_strobe_byte3_n_o,
  output logic col_strobe_byte2_n_o,
  output logic rd_wr_o,
  output logic byte_mask3_o,
  output logic byte_mask2_o,
  output logic byte_mask1_o,
  output logic byte_mask0_o,
  output logic area2_row_strobe_n_o,
  output logic area2_col_strobe_hi_n_o,
  output logic area2_col_strobe_lo_n_o,
  output logic psram_enable_n_o,
  output logic output_enable_refresh_n_o,
  output logic card_enable_a_low_n_o,
  output logic card_enable_a_high_n_o,
  output logic card_enable_b_low_n_o,
  output logic card_enable_b_high_n_o,
  output logic card_oe_n_o,
  output logic card_we_n_o,
  output logic card_io_read_n_o,
  output logic card_io_write_n_o
);
  // ---------------------------------------------------------------
  // decode and wait count
  // ---------------------------------------------------------------
  logic [6:2] hit;
  logic upper_half;
  logic [3:0] waits;
  eas_area_decode u_dec (
    .addr_i(addr_i),
    .hit_o(hit),
    .upper_half_o(upper_half)
  );
  eas_wait_calc u_wait (
    .hit_i(hit),
    .area3_wait_field_i(area3_wait_field_i),
    .area4_wait_field_i(area4_wait_field_i),
    .area5_wait_field_i(area5_wait_field_i),
    .area6_wait_field_i(area6_wait_field_i),
    .waits_o(waits)
  );

  // memory type of the requested area; area 4 is always normal
  eas_mem_e req_type;
  always_comb begin
    req_type = EAS_MEM_NORMAL;
    if (hit[2]) begin
      req_type = area2_type_i;
    end else if (hit[3]) begin
      req_type = area3_type_i;
    end else if (hit[5]) begin
      req_type = area5_type_i;
    end else if (hit[6]) begin
      req_type = area6_type_i;
    end
  end

  // card in area 5 only answers in the lower 32 Mbytes
  logic card_hole;
  assign card_hole = hit[5] && (area5_type_i == EAS_MEM_CARD) && upper_half;
  logic mapped;
  assign mapped = (hit[2] || hit[3] || hit[4] || hit[5] || hit[6]) && !card_hole;

  // ---------------------------------------------------------------
  // latched cycle context
  // ---------------------------------------------------------------
  eas_state_e state;
  eas_mem_e cur_type;
  logic [6:2] cur_area;
  logic cur_write;
  logic cur_io;
  logic [3:0] cur_be;
  logic [3:0] wait_cnt;
  logic [1:0] phase_cnt;
  logic [1:0] hold_cfg;
  logic [1:0] setup_cfg;
  logic [1:0] width_sel;
  logic is_card;
  assign is_card = (cur_type == EAS_MEM_CARD);

  always_comb begin
    setup_cfg = 2'h0;
    hold_cfg = 2'h0;
    if (hit[5]) begin
      setup_cfg = area5_strobe_setup_i;
      hold_cfg = area5_strobe_hold_i;
    end else if (hit[6]) begin
      setup_cfg = area6_strobe_setup_i;
      hold_cfg = area6_strobe_hold_i;
    end
  end

  // bus width presented to the data path
  always_comb begin
    width_sel = `EAS_WIDTH_LONG;
    if (hit[3]) begin
      if (area3_type_i == EAS_MEM_NORMAL || area3_type_i == EAS_MEM_BURST_ROM) begin
        width_sel = area3_width_field_i;
      end else begin
        // word or longword only; SDRAM relies on longword being set
        width_sel = memory_width_bit_i ? `EAS_WIDTH_LONG : 2'h2;
      end
    end else if (hit[5] || hit[6]) begin
      width_sel = hit[5] ? area5_width_field_i : area6_width_field_i;
      // the card port has no longword, so clamp to word
      if (req_type == EAS_MEM_CARD && width_sel == `EAS_WIDTH_LONG) begin
        width_sel = 2'h2;
      end
    end
  end

  // ---------------------------------------------------------------
  // cycle sequencer
  // ---------------------------------------------------------------
  logic strobe_done;
  // external wait counts only for normal memory, burst ROM and card
  assign strobe_done = (wait_cnt == 4'h0) &&
                       (ext_wait_n_i || is_card ? ext_wait_n_i :
                        (cur_type == EAS_MEM_NORMAL || cur_type == EAS_MEM_BURST_ROM) ?
                        ext_wait_n_i : 1'b1);

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      state <= EAS_IDLE;
      cur_type <= EAS_MEM_NORMAL;
      cur_area <= 5'h00;
      cur_write <= 1'b0;
      cur_io <= 1'b0;
      cur_be <= 4'h0;
      wait_cnt <= 4'h0;
      phase_cnt <= 2'h0;
    end else begin
      case (state)
        EAS_IDLE: begin
          if (req_i && mapped) begin
            cur_type <= req_type;
            cur_area <= hit;
            cur_write <= write_i;
            cur_be <= byte_en_i;
            cur_io <= hit[6] && upper_half;
            wait_cnt <= waits;
            phase_cnt <= setup_cfg;
            state <= (req_type == EAS_MEM_CARD) ? EAS_SETUP : EAS_STROBE;
          end
        end
        // half-cycle steps are rounded up to the whole clock
        EAS_SETUP: begin
          if (phase_cnt == 2'h0) begin
            state <= EAS_STROBE;
          end else begin
            phase_cnt <= phase_cnt - 2'h1;
          end
        end
        EAS_STROBE: begin
          if (wait_cnt != 4'h0) begin
            wait_cnt <= wait_cnt - 4'h1;
          end else if (strobe_done) begin
            phase_cnt <= hold_cfg;
            state <= is_card ? EAS_HOLD : EAS_IDLE;
            if (!is_card) begin
              cur_area <= 5'h00;
            end
          end
        end
        EAS_HOLD: begin
          if (phase_cnt == 2'h0) begin
            state <= EAS_IDLE;
            cur_area <= 5'h00;
          end else begin
            phase_cnt <= phase_cnt - 2'h1;
          end
        end
        default: begin
          state <= EAS_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // status and per-cycle configuration outputs
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      done_o <= 1'b0;
      unmapped_o <= 1'b0;
      bus_width_o <= `EAS_WIDTH_LONG;
      burst_pitch_o <= `EAS_PITCH_MIN;
    end else begin
      done_o <= ((state == EAS_STROBE) && strobe_done && !is_card) ||
                ((state == EAS_HOLD) && (phase_cnt == 2'h0));
      unmapped_o <= (state == EAS_IDLE) && req_i && !mapped;
      if ((state == EAS_IDLE) && req_i && mapped) begin
        bus_width_o <= width_sel;
        // pitch follows the wait count but never leaves the 2..10 window
        burst_pitch_o <= !burst_i ? `EAS_PITCH_MIN :
                         ((waits + `EAS_PITCH_MIN) > `EAS_WAIT_MAX) ? `EAS_WAIT_MAX :
                         (waits + `EAS_PITCH_MIN);
      end
    end
  end

  // ---------------------------------------------------------------
  // pin strobes, registered so every output comes from a flip-flop
  // ---------------------------------------------------------------
  logic active;
  logic strobe_phase;
  logic normal_like;
  assign active = (state != EAS_IDLE);
  assign strobe_phase = (state == EAS_STROBE);
  assign normal_like = (cur_type == EAS_MEM_NORMAL) || (cur_type == EAS_MEM_BURST_ROM);

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      busy_o <= 1'b0;
      addr_mux_o <= 1'b0;
      area3_select_n_o <= 1'b1;
      area4_select_n_o <= 1'b1;
      area5_select_n_o <= 1'b1;
      area6_select_n_o <= 1'b1;
      read_strobe_n_o <= 1'b1;
      byte_write_strobe_n_o <= 4'hf;
      rd_wr_o <= 1'b1;
    end else begin
      busy_o <= active;
      // cur_area is one-hot, cleared at cycle end
      area3_select_n_o <= !(active && cur_area[3]);
      area4_select_n_o <= !(active && cur_area[4]);
      area5_select_n_o <= !(active && cur_area[5] && !is_card);
      area6_select_n_o <= !(active && cur_area[6] && !is_card);
      addr_mux_o <= active && (cur_type == EAS_MEM_DRAM || cur_type == EAS_MEM_SDRAM);
      rd_wr_o <= !(active && cur_write);
      read_strobe_n_o <= !(strobe_phase && !cur_write && normal_like);
      byte_write_strobe_n_o <= (strobe_phase && cur_write &&
                                (normal_like || cur_type == EAS_MEM_PSRAM)) ?
                               ~cur_be : 4'hf;
    end
  end

  // dram, sdram and pseudo-SRAM strobes; area 2 dram has its own row strobe and column pair
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      row_strobe_n_o <= 1'b1;
      col_strobe_n_o <= 1'b1;
      col_strobe_byte3_n_o <= 1'b1;
      col_strobe_byte2_n_o <= 1'b1;
      {byte_mask3_o, byte_mask2_o, byte_mask1_o, byte_mask0_o} <= 4'h0;
      area2_row_strobe_n_o <= 1'b1;
      area2_col_strobe_hi_n_o <= 1'b1;
      area2_col_strobe_lo_n_o <= 1'b1;
      psram_enable_n_o <= 1'b1;
      output_enable_refresh_n_o <= 1'b1;
    end else begin
      row_strobe_n_o <= !(active && (cur_area[3] || cur_area[2]) &&
                          (cur_type == EAS_MEM_SDRAM ||
                           (cur_type == EAS_MEM_DRAM && cur_area[3])));
      col_strobe_n_o <= !(strobe_phase && cur_type == EAS_MEM_SDRAM);
      col_strobe_byte3_n_o <= !(strobe_phase && cur_area[3] && cur_type == EAS_MEM_DRAM &&
                                cur_be[3]);
      col_strobe_byte2_n_o <= !(strobe_phase && cur_area[3] && cur_type == EAS_MEM_DRAM &&
                                cur_be[2]);
      // byte masks are high to block a lane
      {byte_mask3_o, byte_mask2_o, byte_mask1_o, byte_mask0_o} <=
        (strobe_phase && cur_type == EAS_MEM_SDRAM) ? ~cur_be : 4'h0;
      area2_row_strobe_n_o <= !(active && cur_area[2] && cur_type == EAS_MEM_DRAM);
      area2_col_strobe_hi_n_o <= !(strobe_phase && cur_area[2] &&
                                   cur_type == EAS_MEM_DRAM && cur_be[1]);
      area2_col_strobe_lo_n_o <= !(strobe_phase && cur_area[2] &&
                                   cur_type == EAS_MEM_DRAM && cur_be[0]);
      psram_enable_n_o <= !(active && cur_type == EAS_MEM_PSRAM);
      output_enable_refresh_n_o <= !(strobe_phase && !cur_write &&
                                     cur_type == EAS_MEM_PSRAM);
    end
  end

  // card strobes; enables span setup and hold around oe/we
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      card_enable_a_low_n_o <= 1'b1;
      card_enable_a_high_n_o <= 1'b1;
      card_enable_b_low_n_o <= 1'b1;
      card_enable_b_high_n_o <= 1'b1;
      card_oe_n_o <= 1'b1;
      card_we_n_o <= 1'b1;
      card_io_read_n_o <= 1'b1;
      card_io_write_n_o <= 1'b1;
    end else begin
      card_enable_a_low_n_o <= !(active && is_card && cur_area[5]);
      card_enable_a_high_n_o <= !(active && is_card && cur_area[5] &&
                                  bus_width_o != 2'h0);
      card_enable_b_low_n_o <= !(active && is_card && cur_area[6]);
      card_enable_b_high_n_o <= !(active && is_card && cur_area[6] &&
                                  bus_width_o != 2'h0);
      card_oe_n_o <= !(strobe_phase && is_card && !cur_io && !cur_write);
      card_we_n_o <= !(strobe_phase && is_card && !cur_io && cur_write);
      card_io_read_n_o <= !(strobe_phase && is_card && cur_io && !cur_write);
      card_io_write_n_o <= !(strobe_phase && is_card && cur_io && cur_write);
    end
  end
endmodule

/* testbench/eas_select_checker.sv */
`timescale 1ns/1ns
// ----------------------------------------
// port checker for the area select block
// ----------------------------------------
module eas_select_checker (
  input wire logic core_clk_i,
  input wire logic srst_i,
  input wire logic req_i,
  input wire logic busy_o,
  input wire logic done_o,
  input wire logic unmapped_o,
  input wire logic [3:0] burst_pitch_o,
  input wire logic addr_mux_o,
  input wire logic area3_select_n_o,
  input wire logic area4_select_n_o,
  input wire logic area5_select_n_o,
  input wire logic area6_select_n_o,
  input wire logic read_strobe_n_o,
  input wire logic [3:0] byte_write_strobe_n_o,
  input wire logic row_strobe_n_o,
  input wire logic card_enable_a_low_n_o,
  input wire logic card_enable_b_low_n_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (srst_i);
  logic [3:0] sel;
  // active-high view of the four area selects
  assign sel = ~{area6_select_n_o, area5_select_n_o, area4_select_n_o, area3_select_n_o};
  // a request taken in idle, busy follows one edge later
  sequence taken_s;
    req_i && !busy_o ##1 busy_o;
  endsequence
  one_select_a: assert property ($onehot0(sel)) else $error("two area selects low");
  select_busy_a: assert property (sel != 4'h0 |-> busy_o) else $error("select outside cycle");
  done_release_a: assert property (done_o |=> sel == 4'h0) else $error("select held at done");
  done_bound_a: assert property (taken_s |-> ##[0:60] done_o) else $error("cycle never ends");
  area4_strobe_a: assert property ($fell(area4_select_n_o) |-> ##[0:2]
    (!read_strobe_n_o || byte_write_strobe_n_o != 4'hf)) else $error("area4 no strobe");
  card_slots_a: assert property (!(!card_enable_a_low_n_o && !card_enable_b_low_n_o))
    else $error("both card slots enabled");
  row_mux_a: assert property (!row_strobe_n_o |-> addr_mux_o) else $error("row without mux");
  pitch_range_a: assert property ($rose(busy_o) |-> burst_pitch_o inside {[2:10]})
    else $error("burst pitch out of range");
  unmapped_quiet_a: assert property (unmapped_o |-> sel == 4'h0)
    else $error("select on unmapped access");
endmodule
bind eas_select eas_select_checker i_chk (.core_clk_i, .srst_i, .req_i, .busy_o, .done_o,
  .unmapped_o, .burst_pitch_o, .addr_mux_o, .area3_select_n_o, .area4_select_n_o,
  .area5_select_n_o, .area6_select_n_o, .read_strobe_n_o, .byte_write_strobe_n_o,
  .row_strobe_n_o, .card_enable_a_low_n_o, .card_enable_b_low_n_o);

/* testbench/eas_mem_partner.sv */
`timescale 1ns/1ns
// ----------------------------------------
// external memory: stretches cycles on the wait line
// ----------------------------------------
module eas_mem_partner (
  input wire logic core_clk_i,
  input wire logic srst_i,
  input wire logic active_i,
  input wire logic [3:0] hold_i,
  output logic ext_wait_n_o
);
  logic was;
  logic [3:0] cnt;
  // count starts when a device is first selected; slow parts hold wait longer
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      was <= 1'b0;
      cnt <= 4'h0;
    end else begin
      was <= active_i;
      // the first wait clock is driven from hold_i directly, so load one less
      if (active_i && !was) cnt <= (hold_i != 4'h0) ? hold_i - 4'h1 : 4'h0;
      else if (cnt != 4'h0) cnt <= cnt - 4'h1;
    end
  end
  // wait low only while selected, released otherwise (pull-up level)
  assign ext_wait_n_o = !(active_i && ((was && cnt != 4'h0) || (!was && hold_i != 4'h0)));
endmodule

/* testbench/tb.sv */
`timescale 1ns/1ns
module tb;
  import eas_pkg::*;
  logic core_clk_i = 0, srst_i = 1, req_i = 0, write_i = 0, burst_i = 0, memory_width_bit_i = 0;
  logic [31:0] addr_i = 0;
  logic [3:0] byte_en_i = 4'hf, area4_wait_field_i = 0, area5_wait_field_i = 0;
  logic [3:0] area6_wait_field_i = 0, hold = 0;
  logic [1:0] area3_width_field_i = 0, area5_width_field_i = 0, area6_width_field_i = 0;
  logic [1:0] area3_wait_field_i = 0, area5_strobe_setup_i = 0, area5_strobe_hold_i = 0;
  logic [1:0] area6_strobe_setup_i = 0, area6_strobe_hold_i = 0;
  eas_mem_e area2_type_i = EAS_MEM_NORMAL, area3_type_i = EAS_MEM_NORMAL;
  eas_mem_e area5_type_i = EAS_MEM_NORMAL, area6_type_i = EAS_MEM_NORMAL;
  logic ext_wait_n_i, busy_o, done_o, unmapped_o, addr_mux_o, area3_select_n_o, area4_select_n_o;
  logic area5_select_n_o, area6_select_n_o, read_strobe_n_o, row_strobe_n_o, col_strobe_n_o;
  logic col_strobe_byte3_n_o, col_strobe_byte2_n_o, rd_wr_o, byte_mask3_o, byte_mask2_o;
  logic byte_mask1_o, byte_mask0_o, area2_row_strobe_n_o, area2_col_strobe_hi_n_o;
  logic area2_col_strobe_lo_n_o, psram_enable_n_o, output_enable_refresh_n_o, card_oe_n_o;
  logic card_enable_a_low_n_o, card_enable_a_high_n_o, card_enable_b_low_n_o, card_we_n_o;
  logic card_enable_b_high_n_o, card_io_read_n_o, card_io_write_n_o;
  logic [1:0] bus_width_o;
  logic [3:0] burst_pitch_o, byte_write_strobe_n_o, lanes;
  logic [15:0] seen;
  integer seed, miscompares = 0, total_checks = 0, k, c, d0;
  logic [31:0] a;
  // ----------------------------------------
  // clock, design and far side
  // ----------------------------------------
  initial forever #4 core_clk_i = ~core_clk_i;
  eas_select i_dut (.core_clk_i, .srst_i, .req_i, .addr_i, .write_i, .byte_en_i, .burst_i,
    .ext_wait_n_i, .area2_type_i, .area3_type_i, .area5_type_i, .area6_type_i,
    .area3_width_field_i, .area5_width_field_i, .area6_width_field_i, .memory_width_bit_i,
    .area3_wait_field_i, .area4_wait_field_i, .area5_wait_field_i, .area6_wait_field_i,
    .area5_strobe_setup_i, .area5_strobe_hold_i, .area6_strobe_setup_i, .area6_strobe_hold_i,
    .busy_o, .done_o, .unmapped_o, .bus_width_o, .burst_pitch_o, .addr_mux_o,
    .area3_select_n_o, .area4_select_n_o, .area5_select_n_o, .area6_select_n_o,
    .read_strobe_n_o, .byte_write_strobe_n_o, .row_strobe_n_o, .col_strobe_n_o,
    .col_strobe_byte3_n_o, .col_strobe_byte2_n_o, .rd_wr_o, .byte_mask3_o, .byte_mask2_o,
    .byte_mask1_o, .byte_mask0_o, .area2_row_strobe_n_o, .area2_col_strobe_hi_n_o,
    .area2_col_strobe_lo_n_o, .psram_enable_n_o, .output_enable_refresh_n_o,
    .card_enable_a_low_n_o, .card_enable_a_high_n_o, .card_enable_b_low_n_o,
    .card_enable_b_high_n_o, .card_oe_n_o, .card_we_n_o, .card_io_read_n_o, .card_io_write_n_o);
  eas_mem_partner i_mem (.core_clk_i, .srst_i, .hold_i(hold), .ext_wait_n_o(ext_wait_n_i),
    .active_i(!(&{area3_select_n_o, area4_select_n_o, area5_select_n_o, area6_select_n_o,
      row_strobe_n_o, psram_enable_n_o, card_enable_a_low_n_o, card_enable_b_low_n_o})));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic [31:0] lim(input integer w, input integer m);
    return (w > m) ? m : w;
  endfunction
  // one access; pins are sampled at falling edges, where they have settled
  task automatic access(input logic [31:0] ad, input logic wr, output integer cyc);
    integer i;
    seen = 0;
    lanes = 0;
    cyc = 0;
    @(negedge core_clk_i);
    addr_i = ad;
    write_i = wr;
    req_i = 1;
    for (i = 0; i < 100; i++) begin
      @(negedge core_clk_i);
      req_i = 0;
      cyc++;
      seen |= {unmapped_o, ~card_io_read_n_o, ~card_enable_b_low_n_o, ~card_enable_a_high_n_o,
        ~card_enable_a_low_n_o, ~output_enable_refresh_n_o, ~psram_enable_n_o,
        ~area2_row_strobe_n_o, ~col_strobe_byte3_n_o, ~col_strobe_n_o, ~row_strobe_n_o,
        ~read_strobe_n_o, ~area6_select_n_o, ~area5_select_n_o, ~area4_select_n_o,
        ~area3_select_n_o};
      lanes |= ~byte_write_strobe_n_o;
      if (done_o === 1'b1 || unmapped_o === 1'b1) break;
    end
    for (k = 0; k < 30 && busy_o !== 1'b0; k++) @(negedge core_clk_i);
    if (i == 100 || k == 30) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, 0, 1);
      complete_run;
    end
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    seed = 99;
    repeat (20) @(negedge core_clk_i);
    srst_i = 0;
    @(negedge core_clk_i);
    chk({area6_select_n_o, area5_select_n_o, area4_select_n_o, area3_select_n_o}, 4'hf);
    for (integer n = 0; n < 8; n++) begin
      if (n == 2) continue;
      a = $random(seed);
      a[28:26] = n[2:0];
      a[25] = 1'b0;
      access(a, 1'b0, c);
      chk(seen & 16'h800f, (n > 2 && n < 7) ? 16'h1 << (n - 3) : 16'h8000);
    end
    $display("decode test done");
    access(32'h1000_0000, 1'b0, d0);
    for (integer n = 0; n < 16; n++) begin
      area4_wait_field_i = n[3:0];
      access(32'h1000_0000, 1'b0, c);
      chk(c - d0, lim(n, 10));
    end
    // the wait pin is only sampled once a software wait has passed
    area4_wait_field_i = 1;
    access(32'h1000_0000, 1'b0, d0);
    hold = 3;
    access(32'h1000_0000, 1'b0, c);
    chk(c - d0, 3);
    hold = 0;
    area4_wait_field_i = 0;
    access(32'h0c00_0000, 1'b0, d0);
    for (integer n = 0; n < 4; n++) begin
      area3_wait_field_i = n[1:0];
      access(32'h0c00_0000, 1'b0, c);
      chk(c - d0, n);
    end
    area3_wait_field_i = 0;
    byte_en_i = $random(seed) | 4'h1;
    access(32'h0c00_0000, 1'b1, c);
    chk(lanes, byte_en_i);
    byte_en_i = 4'hf;
    $display("wait test done");
    burst_i = 1;
    for (integer n = 0; n < 6; n++) begin
      area5_wait_field_i = $unsigned($random(seed)) % 11;
      area6_wait_field_i = area5_wait_field_i;
      access(32'h1400_0000, 1'b0, c);
      chk(burst_pitch_o, lim(area5_wait_field_i + 2, 10));
      access(32'h1800_0000, 1'b0, c);
      chk(burst_pitch_o, lim(area6_wait_field_i + 2, 10));
    end
    burst_i = 0;
    memory_width_bit_i = 1;
    area3_type_i = EAS_MEM_SDRAM;
    access(32'h0c00_0000, 1'b0, d0);
    chk({seen & 16'h0061}, 16'h0061);
    hold = 3;
    access(32'h0c00_0000, 1'b0, c);
    chk(c - d0, 0);
    hold = 0;
    area3_type_i = EAS_MEM_DRAM;
    access(32'h0c00_0000, 1'b0, c);
    chk(seen & 16'h00a1, 16'h00a1);
    area3_type_i = EAS_MEM_PSRAM;
    access(32'h0c00_0000, 1'b0, c);
    chk(seen & 16'h0600, 16'h0600);
    area3_type_i = EAS_MEM_NORMAL;
    area2_type_i = EAS_MEM_SDRAM;
    access(32'h0800_0000, 1'b0, c);
    chk(seen & 16'h0060, 16'h0060);
    area2_type_i = EAS_MEM_DRAM;
    access(32'h0800_0000, 1'b0, c);
    chk(seen & 16'h0100, 16'h0100);
    $display("memory type test done");
    area5_type_i = EAS_MEM_CARD;
    access(32'h1400_0000, 1'b0, d0);
    chk(seen & 16'h1804, 16'h0800);
    area5_width_field_i = 1;
    access(32'h1400_0000, 1'b0, c);
    chk(seen & 16'h1804, 16'h1800);
    area5_width_field_i = 3;
    access(32'h1400_0000, 1'b0, c);
    chk(bus_width_o, 2);
    area5_width_field_i = 1;
    access(32'h1600_0000, 1'b0, c);
    chk(seen & 16'h8000, 16'h8000);
    area5_strobe_setup_i = 3;
    area5_strobe_hold_i = 2;
    access(32'h1400_0000, 1'b0, c);
    chk(c - d0, 5);
    area6_type_i = EAS_MEM_CARD;
    access(32'h1a00_0000, 1'b0, c);
    chk(seen & 16'h6008, 16'h6000);
    access(32'h1800_0000, 1'b0, c);
    chk(seen & 16'h6000, 16'h2000);
    $display("card test done");
    complete_run;
  end
endmodule
